// ===== verilog/cbc_pkg.sv
// constants shared by both ends of the clock buffer control port
// assumes a 250 MHz system clock at each end
package cbc_pkg;
  // ********************************
  // sizes
  // ********************************
  localparam int NOUT = 10;
  localparam int REG_AW = 5;
  localparam int NREG = 32;
  localparam int HDR_BITS = 8;
  localparam int BYTE_BITS = 8;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [6:0] A_GAIN = 7'h00;
  localparam logic [6:0] A_DRIVE = 7'h01;
  localparam logic [6:0] A_LOAD = 7'h02;
  localparam logic [6:0] A_INSEL = 7'h05;
  localparam logic [6:0] A_OUTEN0 = 7'h07;
  localparam logic [6:0] A_OUTEN1 = 7'h08;
  localparam logic [6:0] A_DEVID = 7'h11;
  // ********************************
  // reset values and field positions
  // ********************************
  localparam logic [7:0] RST_GAIN = 8'hFF;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam int GAIN_LSB = 5;
  localparam int OUTEN_W = 5;
  localparam logic [1:0] SEL_MAX = 2'h2;
  // ********************************
  // crystal settings, capacitance in fF
  // ********************************
  localparam int LOAD_STEP_FF = 250;
  localparam int LOAD_MAX_FF = 21750;
  localparam int LOAD_PIN_FF = 8000;
  localparam logic [7:0] LOAD_MAX_CODE = 8'(LOAD_MAX_FF / LOAD_STEP_FF);
  localparam logic [6:0] LOAD_PIN_CODE = 7'(LOAD_PIN_FF / LOAD_STEP_FF);
  localparam int GAIN_STEPS = 8;
  localparam int RES_STEPS = 6;
  localparam logic [2:0] RES_MAX = 3'(RES_STEPS - 1);
  localparam logic [2:0] PIN_GAIN = 3'h0;
  localparam logic [2:0] PIN_RES = 3'h0;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_NS = 4;
  localparam int SCK_PERIOD_NS = 80;
  localparam logic [4:0] SCK_HALF_CYC = 5'(SCK_PERIOD_NS / (2 * CLK_NS));
  localparam logic [1:0] STRAP_WAIT = 2'h2;
endpackage

// ===== verilog/cbc_if.sv
// pins between the buffer control port and its host controller
// assumes the bench ties both ends to one instance
interface cbc_if;
  logic strap_o;
  logic shared_o;
  logic shared_oe;
  logic sck_o;
  logic sdi_o;
  logic [1:0] choice_o;
  logic sdo_o;
  logic sdo_oe;
  logic shared_line;
  logic sdo_line;
  // weak pull on the shared pin follows the strap
  assign shared_line = shared_oe ? shared_o : strap_o;
  // undriven read data line settles low
  assign sdo_line = sdo_oe ? sdo_o : 1'b0;
  modport dev (
    input strap_o,
    input shared_line,
    input sck_o,
    input sdi_o,
    input choice_o,
    output sdo_o,
    output sdo_oe
  );
  modport host (
    output strap_o,
    output shared_o,
    output shared_oe,
    output sck_o,
    output sdi_o,
    output choice_o,
    input sdo_line
  );
endinterface

// ===== verilog/cbc_dev.sv
// device end: mode strap, pin-mode output gating, serial slave, registers
// assumes every pin and input clock is asynchronous to clock
//
// Behaviour
// RQ1 - strap low pins control, high serial
// RQ2 - system fixes strap, never changes it
// RQ3 - pin mode uses enable and choice pins
// RQ4 - disable outputs at selected clock falling edge
// RQ5 - enable drives outputs low immediately
// RQ6 - outputs track clock after first falling edge
// RQ7 - serial mode is four-wire slave
// RQ8 - host ignores read line during writes
// RQ9 - read ignores input after address
// RQ10 - clock low at select means msb first
// RQ11 - clock high at select means lsb first
// RQ12 - rw bit, seven address bits, data bytes
// RQ13 - host holds select for whole transfer
// RQ14 - select held low continues burst
// RQ15 - address increments after every byte
// RQ16 - serial load capacitance programmable, quarter steps
// RQ17 - eight gain steps, six resistor steps
// RQ18 - pin mode load fixed at eight picofarad
// RQ19 - shared pin is enable or select
// RQ20 - read line undriven unless reading
module cbc_dev #(
  parameter logic [7:0] DEVID = 8'h5A // arbitrary identification value
) (
  input wire logic clock,
  input wire logic rstn,
  cbc_if.dev pins,
  input wire logic [2:0] in_clk,
  output logic serial_mode,
  output logic [cbc_pkg::NOUT-1:0] out_level,
  output logic [cbc_pkg::NOUT-1:0] out_drive,
  output logic [6:0] load_code,
  output logic [2:0] gain_step,
  output logic [2:0] res_step
);
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [1:0] strap_s;
    logic [1:0] strap_cnt;
    logic strap_taken;
    logic serial;
    logic [1:0] cs_s;
    logic [1:0] sck_s;
    logic [1:0] sdi_s;
    logic cs_d;
    logic sck_d;
    logic [1:0][1:0] sel_s;
    logic [1:0][2:0] ref_s;
    logic ref_d;
    logic in_frame;
    logic lsb_first;
    logic hdr_done;
    logic rd;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [6:0] addr;
    logic [7:0] rbyte;
    logic sdo;
    logic sdo_oe;
    logic [cbc_pkg::NOUT-1:0] gate;
    logic [cbc_pkg::NOUT-1:0] drive;
    logic [cbc_pkg::NOUT-1:0] level;
    logic [6:0] load;
    logic [2:0] gain;
    logic [2:0] res;
    logic [cbc_pkg::NREG-1:0][7:0] regs;
  } cbc_dev_st_t;

  cbc_dev_st_t q;
  cbc_dev_st_t d;

  // ********************************
  // register read value
  // ********************************
  function automatic logic [7:0] cbc_rdval(input cbc_dev_st_t s, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == cbc_pkg::A_DEVID) begin
      v = DEVID;
    end else if (a < 7'(cbc_pkg::NREG)) begin
      v = s.regs[a[cbc_pkg::REG_AW-1:0]];
    end
    return v;
  endfunction

  // ********************************
  // next state
  // ********************************
  always_comb begin
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic bit_in;
    logic [1:0] sel;
    logic cur;
    logic fall;
    logic en;
    logic [cbc_pkg::NOUT-1:0] outen;
    logic [2:0] idx;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    sck_rise = 1'b0;
    bit_in = 1'b0;
    sel = 2'h0;
    cur = 1'b0;
    fall = 1'b0;
    en = 1'b0;
    outen = '0;
    idx = 3'h0;
    d = q;
    // two-flop synchronisers
    d.strap_s = {q.strap_s[0], pins.strap_o};
    d.cs_s = {q.cs_s[0], pins.shared_line};
    d.sck_s = {q.sck_s[0], pins.sck_o};
    d.sdi_s = {q.sdi_s[0], pins.sdi_o};
    d.sel_s = {q.sel_s[0], pins.choice_o};
    d.ref_s = {q.ref_s[0], in_clk};
    d.cs_d = q.cs_s[1];
    d.sck_d = q.sck_s[1];
    // strap taken once, after it has passed the synchroniser
    if (!q.strap_taken) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == cbc_pkg::STRAP_WAIT) begin
        d.strap_taken = 1'b1;
        d.serial = q.strap_s[1]; // RQ1
      end
    end
    // serial slave, active only in serial mode
    if (q.strap_taken && q.serial) begin
      cs_fall = q.cs_d && !q.cs_s[1]; // RQ19
      cs_rise = !q.cs_d && q.cs_s[1];
      sck_rise = q.sck_s[1] && !q.sck_d && q.in_frame;
      bit_in = q.sdi_s[1];
    end
    if (cs_fall) begin
      d.in_frame = 1'b1;
      d.lsb_first = q.sck_s[1]; // RQ10 RQ11
      d.hdr_done = 1'b0;
      d.bitn = 3'h0;
      d.addr = 7'h00;
      d.sdo_oe = 1'b0;
    end else if (cs_rise) begin
      d.in_frame = 1'b0;
      d.sdo_oe = 1'b0; // RQ20
    end else if (sck_rise) begin
      d.bitn = q.bitn + 3'h1;
      if (!q.hdr_done) begin
        // header: rw bit then address in chosen order
        if (q.bitn == 3'h0) begin
          d.rd = bit_in; // RQ12
        end else if (q.lsb_first) begin
          d.addr = {bit_in, q.addr[6:1]};
        end else begin
          d.addr = {q.addr[5:0], bit_in};
        end
        if (q.bitn == 3'(cbc_pkg::HDR_BITS - 1)) begin
          d.hdr_done = 1'b1;
          d.rbyte = cbc_rdval(q, d.addr);
          d.sdo_oe = d.rd; // RQ20
        end
      end else if (q.rd) begin
        // read data phase, input line is not looked at
        if (q.bitn == 3'(cbc_pkg::BYTE_BITS - 1)) begin // RQ9
          d.addr = q.addr + 7'h01; // RQ15
          d.rbyte = cbc_rdval(q, d.addr); // RQ14
        end
      end else begin
        // write data phase
        d.sh = q.lsb_first ? {bit_in, q.sh[7:1]} : {q.sh[6:0], bit_in};
        if (q.bitn == 3'(cbc_pkg::BYTE_BITS - 1)) begin
          if (q.addr < 7'(cbc_pkg::NREG) && q.addr != cbc_pkg::A_DEVID) begin
            d.regs[q.addr[cbc_pkg::REG_AW-1:0]] = d.sh;
          end
          d.addr = q.addr + 7'h01; // RQ15 RQ14
        end
      end
    end
    // read data bit for the coming clock
    idx = d.lsb_first ? d.bitn : 3'h7 - d.bitn;
    d.sdo = d.sdo_oe ? d.rbyte[idx] : 1'b0; // RQ7
    // clock choice and output enables per mode
    outen = {q.regs[cbc_pkg::A_OUTEN1][cbc_pkg::OUTEN_W-1:0],
             q.regs[cbc_pkg::A_OUTEN0][cbc_pkg::OUTEN_W-1:0]};
    sel = q.serial ? q.regs[cbc_pkg::A_INSEL][1:0] : q.sel_s[1]; // RQ3
    if (sel > cbc_pkg::SEL_MAX) begin
      sel = cbc_pkg::SEL_MAX;
    end
    cur = q.ref_s[1][sel];
    fall = q.ref_d && !cur;
    d.ref_d = cur;
    // output gating on falling edges of the chosen clock
    for (int i = 0; i < cbc_pkg::NOUT; i++) begin
      en = q.strap_taken && (q.serial ? outen[i] : q.cs_s[1]); // RQ3 RQ19
      if (en && !q.drive[i]) begin
        d.drive[i] = 1'b1; // RQ5
      end
      if (fall) begin
        d.gate[i] = en; // RQ6
        if (!en) begin
          d.drive[i] = 1'b0; // RQ4
        end
      end
      d.level[i] = d.gate[i] && cur;
    end
    // crystal settings
    if (q.serial) begin
      d.load = (q.regs[cbc_pkg::A_LOAD] > cbc_pkg::LOAD_MAX_CODE) ?
               cbc_pkg::LOAD_MAX_CODE[6:0] : q.regs[cbc_pkg::A_LOAD][6:0]; // RQ16
      d.gain = q.regs[cbc_pkg::A_GAIN][cbc_pkg::GAIN_LSB +: 3]; // RQ17
      d.res = (q.regs[cbc_pkg::A_DRIVE][2:0] > cbc_pkg::RES_MAX) ?
              cbc_pkg::RES_MAX : q.regs[cbc_pkg::A_DRIVE][2:0]; // RQ17
    end else begin
      d.load = cbc_pkg::LOAD_PIN_CODE; // RQ18
      d.gain = cbc_pkg::PIN_GAIN;
      d.res = cbc_pkg::PIN_RES;
    end
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
      q.cs_s <= 2'h3;
      q.cs_d <= 1'b1;
      q.load <= cbc_pkg::LOAD_PIN_CODE;
      for (int r = 0; r < cbc_pkg::NREG; r++) begin
        q.regs[r] <= cbc_pkg::RST_OTHER;
      end
      q.regs[cbc_pkg::A_GAIN] <= cbc_pkg::RST_GAIN;
    end else begin
      q <= d;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign serial_mode = q.serial;
  assign out_level = q.level;
  assign out_drive = q.drive;
  assign load_code = q.load;
  assign gain_step = q.gain;
  assign res_step = q.res;
  assign pins.sdo_o = q.sdo;
  assign pins.sdo_oe = q.sdo_oe;
endmodule

// ===== verilog/cbc_host.sv
// host end: drives the strap, the shared pin and the serial master
// assumes the user keeps write data ready one byte ahead
module cbc_host (
  input wire logic clock,
  input wire logic rstn,
  cbc_if.host pins,
  input wire logic strap_cfg,
  input wire logic [1:0] choice_cfg,
  input wire logic oe_level,
  input wire logic start,
  input wire logic cmd_rd,
  input wire logic [6:0] cmd_addr,
  input wire logic cmd_lsb,
  input wire logic [4:0] cmd_len,
  input wire logic [7:0] wdata,
  output logic wtake,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic busy,
  output logic done
);
  typedef enum logic [2:0] {CBC_IDLE, CBC_SETUP, CBC_ARM, CBC_LOW, CBC_HIGH, CBC_TAIL} cbc_hst_t;
  typedef struct packed {
    cbc_hst_t st;
    logic strap_set;
    logic strap;
    logic [1:0] choice;
    logic shared;
    logic cs_n;
    logic sck;
    logic sdi;
    logic [1:0] sdo_s;
    logic [4:0] timer;
    logic rd;
    logic lsb;
    logic hdr;
    logic [2:0] p;
    logic [4:0] left;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rdata;
    logic rvalid;
    logic wtake;
    logic done;
  } cbc_host_st_t;

  cbc_host_st_t q;
  cbc_host_st_t d;

  // ********************************
  // bit to send at position p
  // ********************************
  function automatic logic cbc_txbit(input cbc_host_st_t s, input logic [2:0] p);
    logic b;
    b = 1'b0;
    if (s.hdr) begin
      if (p == 3'h0) begin
        b = s.rd; // RQ12
      end else begin
        b = s.lsb ? s.tx[p - 3'h1] : s.tx[3'h7 - p];
      end
    end else if (!s.rd) begin
      b = s.lsb ? s.tx[p] : s.tx[3'h7 - p]; // RQ10 RQ11
    end
    return b;
  endfunction

  // ********************************
  // next state
  // ********************************
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.wtake = 1'b0;
    d.done = 1'b0;
    d.sdo_s = {q.sdo_s[0], pins.sdo_line};
    d.choice = choice_cfg;
    // strap fixed once after reset
    if (!q.strap_set) begin
      d.strap_set = 1'b1;
      d.strap = strap_cfg; // RQ2
    end
    d.shared = q.strap ? q.cs_n : oe_level;
    if (q.timer != 5'h00) begin
      d.timer = q.timer - 5'h01;
    end
    case (q.st)
      CBC_IDLE: begin
        if (start && q.strap_set && q.strap) begin
          d.rd = cmd_rd;
          d.lsb = cmd_lsb;
          d.tx = {1'b0, cmd_addr};
          d.hdr = 1'b1;
          d.p = 3'h0;
          d.left = (cmd_len == 5'h00) ? 5'h01 : cmd_len;
          d.sck = cmd_lsb; // RQ10 RQ11
          d.timer = cbc_pkg::SCK_HALF_CYC - 5'h01;
          d.st = CBC_SETUP;
        end
      end
      CBC_SETUP: begin
        if (q.timer == 5'h00) begin
          d.cs_n = 1'b0;
          d.timer = cbc_pkg::SCK_HALF_CYC - 5'h01;
          d.st = CBC_ARM;
        end
      end
      CBC_ARM: begin
        if (q.timer == 5'h00) begin
          d.sck = 1'b0;
          d.sdi = cbc_txbit(q, q.p);
          d.timer = cbc_pkg::SCK_HALF_CYC - 5'h01;
          d.st = CBC_LOW;
        end
      end
      CBC_LOW: begin
        if (q.timer == 5'h00) begin
          d.sck = 1'b1;
          d.rx = q.lsb ? {q.sdo_s[1], q.rx[7:1]} : {q.rx[6:0], q.sdo_s[1]};
          d.timer = cbc_pkg::SCK_HALF_CYC - 5'h01;
          d.st = CBC_HIGH;
        end
      end
      CBC_HIGH: begin
        if (q.timer == 5'h00) begin
          d.sck = 1'b0;
          d.p = q.p + 3'h1;
          d.timer = cbc_pkg::SCK_HALF_CYC - 5'h01;
          d.st = CBC_LOW;
          if (q.p == 3'h7) begin
            if (q.hdr) begin
              d.hdr = 1'b0;
            end else begin
              d.left = q.left - 5'h01; // RQ14
              d.rdata = q.rx;
              d.rvalid = q.rd; // RQ8
            end
            if (!q.hdr && q.left == 5'h01) begin
              d.st = CBC_TAIL; // RQ13
            end else if (!q.rd) begin
              d.tx = wdata;
              d.wtake = 1'b1;
            end
          end
          if (d.st == CBC_LOW) begin
            d.sdi = cbc_txbit(d, d.p);
          end else begin
            d.sdi = 1'b0;
          end
        end
      end
      CBC_TAIL: begin
        if (q.timer == 5'h00) begin
          d.cs_n = 1'b1;
          d.done = 1'b1;
          d.st = CBC_IDLE;
        end
      end
      default: begin
        d.st = CBC_IDLE;
      end
    endcase
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
      q.st <= CBC_IDLE;
      q.cs_n <= 1'b1;
      // strap shown from reset, so the device's capture sees it settled
      q.strap <= strap_cfg; // RQ2
    end else begin
      q <= d;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign pins.strap_o = q.strap;
  assign pins.shared_o = q.shared;
  assign pins.shared_oe = q.strap_set;
  assign pins.sck_o = q.sck;
  assign pins.sdi_o = q.sdi;
  assign pins.choice_o = q.choice;
  assign wtake = q.wtake;
  assign rdata = q.rdata;
  assign rvalid = q.rvalid;
  assign busy = (q.st != CBC_IDLE);
  assign done = q.done;
endmodule

// ===== verif/cbc_props.sv
// wire checks between the device end and the host end
// assumes the bench feeds the interface signals in by name
module cbc_props (
  input wire logic clock,
  input wire logic rstn,
  input wire logic strap_o,
  input wire logic shared_line,
  input wire logic sck_o,
  input wire logic sdi_o,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] rises_q;
  logic sck_q;
  logic rw_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // ****
  // helpers
  // ****
  // counts serial clock rises in a frame, keeps the first bit
  always_ff @(posedge clock) begin
    sck_q <= sck_o;
    if (!rstn || shared_line) begin
      rises_q <= 9'h000;
      rw_q <= 1'b0;
    end else if (sck_o && !sck_q) begin
      rises_q <= rises_q + 9'h001;
      if (rises_q == 9'h000) begin
        rw_q <= sdi_o;
      end
    end
  end
  // ****
  // assertions
  // ****
  rd_only_a: assert property ($rose(sdo_oe) |-> rises_q == 9'h008 && rw_q)
    else $error("read line driven outside a read data phase");
  idle_oe_a: assert property (shared_line [*5] |-> !sdo_oe)
    else $error("read line driven while deselected");
  pin_oe_a: assert property (!strap_o |-> !sdo_oe)
    else $error("read line driven in pin mode");
  sdo_hold_a: assert property (sdo_oe && $rose(sck_o) |-> $stable(sdo_o))
    else $error("read bit moved at the sampling edge");
  cs_end_a: assert property (strap_o && $past(strap_o) && $rose(shared_line)
    |-> rises_q >= 9'h010 && rises_q[2:0] == 3'h0 && !sck_o)
    else $error("frame ended off a byte boundary");
  sdi_hold_a: assert property (!shared_line && $rose(sck_o) |-> $stable(sdi_o))
    else $error("input bit moved at the sampling edge");
  rd_keep_a: assert property (sdo_oe && !shared_line |=> sdo_oe)
    else $error("read line released inside a frame");
  order_lvl_a: assert property (strap_o && $fell(shared_line) |-> $stable(sck_o) [*8])
    else $error("clock level moved at frame start");
  cover property ($rose(sdo_oe));
  cover property (strap_o && $fell(shared_line) && sck_o);
  cover property (strap_o && $fell(shared_line) && !sck_o);
endmodule

// ===== verif/clock_buffer_control_port_bench.sv
// self-checking bench joining the device end to the host end
// assumes both ends share one clock and one synchronous reset
module clock_buffer_control_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] DEV_ID = 8'h3C; // arbitrary identification value
  logic clock, rstn, strap_cfg, oe_level, start, cmd_rd, cmd_lsb, sck_p;
  logic [1:0] choice_cfg;
  logic [6:0] cmd_addr;
  logic [4:0] cmd_len;
  logic [7:0] wdata, rdata;
  logic [2:0] in_clk, gain_step, res_step;
  logic serial_mode, wtake, rvalid, busy, done;
  logic [9:0] out_level, out_drive;
  logic [6:0] load_code;
  logic [7:0] exp_q[$];
  logic bits[$];
  logic [7:0] d[4];
  logic [7:0] g[4];
  int n_errors = 0;
  int check_count = 0;
  cbc_if pins ();
  cbc_dev #(.DEVID(DEV_ID)) cbc_dev_i (.clock(clock), .rstn(rstn), .pins(pins),
    .in_clk(in_clk), .serial_mode(serial_mode), .out_level(out_level),
    .out_drive(out_drive), .load_code(load_code), .gain_step(gain_step), .res_step(res_step));
  cbc_host cbc_host_i (.clock(clock), .rstn(rstn), .pins(pins), .strap_cfg(strap_cfg),
    .choice_cfg(choice_cfg), .oe_level(oe_level), .start(start), .cmd_rd(cmd_rd),
    .cmd_addr(cmd_addr), .cmd_lsb(cmd_lsb), .cmd_len(cmd_len), .wdata(wdata),
    .wtake(wtake), .rdata(rdata), .rvalid(rvalid), .busy(busy), .done(done));
  cbc_props cbc_props_i (.clock(clock), .rstn(rstn), .strap_o(pins.strap_o),
    .shared_line(pins.shared_line), .sck_o(pins.sck_o), .sdi_o(pins.sdi_o),
    .sdo_o(pins.sdo_o), .sdo_oe(pins.sdo_oe));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input logic s);
    strap_cfg <= s;
    rstn <= 1'b0;
    cyc(4);
    rstn <= 1'b1;
    cyc(12);
  endtask
  // one frame, then the header seen on the wire, and for writes the first byte too
  task automatic xfer(input logic rd, input logic [6:0] a, input logic lsb, input int n);
    int k;
    int w;
    k = 0;
    w = 0;
    bits.delete();
    cmd_rd <= rd;
    cmd_addr <= a;
    cmd_lsb <= lsb;
    cmd_len <= 5'(n);
    wdata <= d[0];
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    cyc(1);
    chk(10'(busy), 10'h001);
    while (done !== 1'b1 && w < 4000) begin
      cyc(1);
      w++;
      if (wtake === 1'b1) begin
        k++;
        wdata <= d[k];
      end
    end
    if (w >= 4000) begin
      n_errors++;
      $display("MISMATCH t=%0t frame never finished", $time);
      end_sim();
    end
    chk(10'(busy), 10'h000);
    chk(10'(bits.size()), 10'(8 * (n + 1)));
    for (int j = 0; j < (rd ? 8 : 16); j++) begin
      chk(10'(bits[j]), j == 0 ? rd : j < 8 ? (lsb ? a[j-1] : a[7-j]) :
        (lsb ? d[0][j-8] : d[0][15-j]));
    end
  endtask
  // enable, track and disable the outputs on one choice
  task automatic pin_case(input logic [1:0] c);
    logic [2:0] hi;
    hi = 3'h1 << ((c == 2'h3) ? 2 : c);
    choice_cfg <= c;
    in_clk <= 3'h0;
    cyc(10);
    chk(out_drive, 10'h000);
    in_clk <= hi;
    oe_level <= 1'b1;
    cyc(10);
    chk(out_drive, 10'h3FF);
    chk(out_level, 10'h000);
    in_clk <= ~hi;
    cyc(10);
    chk(out_level, 10'h000);
    in_clk <= hi;
    cyc(10);
    chk(out_level, 10'h3FF);
    oe_level <= 1'b0;
    cyc(10);
    chk(out_drive, 10'h3FF);
    in_clk <= 3'h0;
    cyc(10);
    chk(out_drive, 10'h000);
  endtask
  // ****
  // monitors and stimulus
  // ****
  // compare each read byte with the oldest expected one
  always @(posedge clock) begin
    if (rvalid === 1'b1) begin
      chk(rdata, (exp_q.size() > 0) ? 10'(exp_q.pop_front()) : 10'h3FF);
    end
  end
  // collect input bits at each serial clock rise in a frame
  always @(posedge clock) begin
    sck_p <= pins.sck_o;
    if (pins.strap_o && !pins.shared_line && pins.sck_o && !sck_p) begin
      bits.push_back(pins.sdi_o);
    end
  end
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    void'($urandom(24));
    rstn = 1'b0;
    strap_cfg = 1'b0;
    oe_level = 1'b0;
    start = 1'b0;
    cmd_rd = 1'b0;
    cmd_lsb = 1'b0;
    choice_cfg = 2'h0;
    cmd_addr = 7'h00;
    cmd_len = 5'h00;
    wdata = 8'h00;
    in_clk = 3'h0;
    cyc(1);
    do_reset(1'b0);
    chk(serial_mode, 10'h000);
    chk(load_code, cbc_pkg::LOAD_PIN_CODE);
    chk({gain_step, res_step}, {cbc_pkg::PIN_GAIN, cbc_pkg::PIN_RES});
    for (int c = 0; c < 4; c++) begin
      pin_case(2'(c));
    end
    do_reset(1'b1);
    chk(serial_mode, 10'h001);
    chk(gain_step, cbc_pkg::RST_GAIN[7:5]);
    chk(load_code, cbc_pkg::RST_OTHER[6:0]);
    foreach (d[i]) d[i] = 8'($urandom);
    g = d;
    xfer(1'b0, cbc_pkg::A_GAIN, 1'b0, 3);
    chk(gain_step, d[0][7:5]);
    chk(res_step, (d[1][2:0] > cbc_pkg::RES_MAX) ? cbc_pkg::RES_MAX : d[1][2:0]);
    chk(load_code, (d[2] > cbc_pkg::LOAD_MAX_CODE) ? cbc_pkg::LOAD_MAX_CODE : d[2]);
    d[0] = cbc_pkg::LOAD_MAX_CODE + 8'h01;
    xfer(1'b0, cbc_pkg::A_LOAD, 1'b1, 1);
    chk(load_code, cbc_pkg::LOAD_MAX_CODE);
    d[0] = 8'hA5;
    xfer(1'b0, cbc_pkg::A_DEVID, 1'b0, 1);
    exp_q.push_back(g[0]);
    exp_q.push_back(g[1]);
    exp_q.push_back(cbc_pkg::LOAD_MAX_CODE + 8'h01);
    xfer(1'b1, cbc_pkg::A_GAIN, 1'b1, 3);
    exp_q.push_back(DEV_ID);
    exp_q.push_back(cbc_pkg::RST_OTHER);
    xfer(1'b1, cbc_pkg::A_DEVID, 1'b0, 2);
    cyc(20);
    chk(10'(exp_q.size()), 10'h000);
    end_sim();
  end
endmodule
